//--- pwr_budget_pkg.sv
// Shared constants, field layouts and carrier types for the power budget
// register bank.
// Assumes a single 125 MHz core clock and a plain word-wide register port.
package pwr_budget_pkg;

  // ---------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CAP_HEADER = 12'h280;
  localparam logic [ADDR_W-1:0] OFF_DATA_SELECT = 12'h284;
  localparam logic [ADDR_W-1:0] OFF_DATA_WINDOW = 12'h288;
  localparam logic [ADDR_W-1:0] OFF_CAP_FLAGS = 12'h28C;
  localparam logic [ADDR_W-1:0] OFF_VALUE_BASE = 12'h300;
  localparam logic [ADDR_W-1:0] OFF_SWITCH_CONTROL = 12'h404;
  localparam logic [ADDR_W-1:0] OFF_LOCK_STATUS = 12'h408;
  localparam int VALUE_COUNT = 8;
  localparam int VALUE_STRIDE = 4;

  // ---------------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------------
  localparam int SELECT_W = 8;
  localparam int SA_BIT = 0;
  localparam int UNLOCK_BIT = 0;
  localparam int LOCKED_WRITE_BIT = 0;

  // ---------------------------------------------------------------------
  // Reset values and field encodings
  // ---------------------------------------------------------------------
  localparam logic [DATA_W-1:0] CAP_HEADER_RESET = 32'h0000_0000;
  localparam logic [SELECT_W-1:0] SELECT_RESET = 8'h00;
  localparam logic [SELECT_W-1:0] SELECT_LAST = 8'h07;
  localparam logic SA_RESET = 1'b0;
  localparam logic UNLOCK_RESET = 1'b0;
  localparam logic [15:0] CAP_ID_POWER_BUDGET = 16'h0004;
  localparam logic [3:0] CAP_VER_ONE = 4'h1;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  // Layout of the capability header word, most significant field first.
  typedef struct packed {
    logic [11:0] next_capability_pointer;
    logic [3:0] capability_version;
    logic [15:0] capability_identifier;
  } cap_header_s;

endpackage

//--- budget_value_store.sv
// Storage for the eight power budget data value words.
// Assumes the caller gates writes; this store has no reset so its
// contents survive every reset of the surrounding logic.
`timescale 1ns/1ps

module budget_value_store
  import pwr_budget_pkg::*;
#(
  parameter int COUNT = VALUE_COUNT,
  parameter int WIDTH = DATA_W
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wr_en,
  input wire logic [$clog2(COUNT)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic [$clog2(COUNT)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);

  typedef struct packed {
    logic [COUNT-1:0][WIDTH-1:0] word;
  } store_s;

  store_s state_reg;
  store_s state_next;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (wr_en) begin
      state_next.word[wr_idx] = wr_data;
    end
  end

  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  // Deliberately unreset: the words are sticky and have no defined value.
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  assign rd_data = state_reg.word[rd_idx];

endmodule

//--- power_budget_capability_regs.sv
// Power budgeting capability register bank of the switch.
// Assumes a same-clock master on the plain register port, a fundamental
// reset on arst_n and a synchronous hot reset from core logic.
//
// What this block does
// - Header low 16 bits hold capability identifier
// - Header bits 19:16 hold capability version
// - Eight-bit selector picks word for window
// - Selector above seven makes window read zero
// - Window returns selected word, else zero
// - Bit zero flags power already system allocated
// - Eight value words, first at 0x300
// - Value words writable only while unlocked
// - Locked value words discard writes unchanged
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

module power_budget_capability_regs
  import pwr_budget_pkg::*;
#(
  parameter int COUNT = VALUE_COUNT
) (
  // Clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hot_reset,
  // Register port
  input wire bus_req_s req,
  output logic [DATA_W-1:0] rdata,
  // Status towards the switch core
  output logic system_allocated_flag,
  output logic budget_value_unlock,
  output logic capability_present
);

  localparam int IDX_W = $clog2(COUNT);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    cap_header_s header;
    logic [SELECT_W-1:0] value_selector;
    logic sa;
    logic unlock;
    logic locked_write;
    logic present;
    logic [DATA_W-1:0] rdata;
  } regs_s;

  regs_s state_reg;
  regs_s state_next;

  // ---------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------
  // True when the address falls on one of the value words.
  function automatic logic is_value_addr(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] span;
    logic hit;
    span = ADDR_W'(COUNT * VALUE_STRIDE);
    hit = (a >= OFF_VALUE_BASE) && (a < OFF_VALUE_BASE + span);
    return hit && (a[1:0] == 2'b00);
  endfunction

  // Word index of a value address; only meaningful when is_value_addr.
  function automatic logic [IDX_W-1:0] value_index(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] rel;
    rel = a - OFF_VALUE_BASE;
    return rel[IDX_W+1:2];
  endfunction

  // Whether a selector value names an implemented word.
  function automatic logic select_in_range(
    input logic [SELECT_W-1:0] s
  );
    return s <= SELECT_LAST;
  endfunction

  // ---------------------------------------------------------------------
  // Value word storage
  // ---------------------------------------------------------------------
  logic value_wr;
  logic [IDX_W-1:0] value_wr_idx;
  logic [IDX_W-1:0] value_rd_idx;
  logic [DATA_W-1:0] value_rd_data;
  logic value_hit;

  assign value_hit = is_value_addr(req.addr);
  assign value_wr_idx = value_index(req.addr);
  assign value_wr = req.wr && value_hit && state_reg.unlock;

  // A direct read of a value word uses the bus address; otherwise the
  // store is steered by the selector so the window can be served.
  assign value_rd_idx = value_hit ? value_wr_idx
                                  : state_reg.value_selector[IDX_W-1:0];

  budget_value_store #(
    .COUNT(COUNT),
    .WIDTH(DATA_W)
  ) u_store (
    .clk(clk),
    .wr_en(value_wr),
    .wr_idx(value_wr_idx),
    .wr_data(req.wdata),
    .rd_idx(value_rd_idx),
    .rd_data(value_rd_data)
  );

  // ---------------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] read_word;

  always_comb begin
    read_word = ZERO_WORD;
    if (value_hit) begin
      read_word = value_rd_data;
    end else begin
      case (req.addr)
        OFF_CAP_HEADER: begin
          read_word = state_reg.header;
        end
        OFF_DATA_SELECT: begin
          read_word = {{(DATA_W-SELECT_W){1'b0}},
                       state_reg.value_selector};
        end
        OFF_DATA_WINDOW: begin
          if (select_in_range(state_reg.value_selector)) begin
            read_word = value_rd_data;
          end else begin
            read_word = ZERO_WORD;
          end
        end
        OFF_CAP_FLAGS: begin
          read_word[SA_BIT] = state_reg.sa;
        end
        OFF_SWITCH_CONTROL: begin
          read_word[UNLOCK_BIT] = state_reg.unlock;
        end
        OFF_LOCK_STATUS: begin
          read_word[LOCKED_WRITE_BIT] = state_reg.locked_write;
        end
        default: begin
          read_word = ZERO_WORD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  // Header and flag fields are lockable: like the value words they take
  // writes only while unlocked; a refused write to any of them sets locked_write.
  logic locked_write_event;
  logic header_wr;
  logic flags_wr;

  assign header_wr = req.wr && (req.addr == OFF_CAP_HEADER);
  assign flags_wr = req.wr && (req.addr == OFF_CAP_FLAGS);
  assign locked_write_event = !state_reg.unlock &&
                              (value_wr == 1'b0) &&
                              req.wr &&
                              (value_hit || header_wr || flags_wr);

  always_comb begin
    state_next = state_reg;
    state_next.rdata = req.rd ? read_word : ZERO_WORD;

    if (req.wr) begin
      case (req.addr)
        OFF_CAP_HEADER: begin
          if (state_reg.unlock) begin
            state_next.header = cap_header_s'(req.wdata);
          end
        end
        OFF_DATA_SELECT: begin
          state_next.value_selector = req.wdata[SELECT_W-1:0];
        end
        OFF_CAP_FLAGS: begin
          if (state_reg.unlock) begin
            state_next.sa = req.wdata[SA_BIT];
          end
        end
        OFF_SWITCH_CONTROL: begin
          state_next.unlock = req.wdata[UNLOCK_BIT];
        end
        OFF_LOCK_STATUS: begin
          if (req.wdata[LOCKED_WRITE_BIT]) begin
            state_next.locked_write = 1'b0;
          end
        end
        default: begin
          state_next.locked_write = state_reg.locked_write;
        end
      endcase
    end

    // A refused write in the same cycle as the clear still records.
    if (locked_write_event) begin
      state_next.locked_write = 1'b1;
    end

    state_next.present =
      (state_next.header.capability_identifier == CAP_ID_POWER_BUDGET) &&
      (state_next.header.capability_version == CAP_VER_ONE);

    // Hot reset returns the non-sticky fields to their reset values; the
    // value words sit in the unreset store and are untouched.
    if (hot_reset) begin
      state_next.header = cap_header_s'(CAP_HEADER_RESET);
      state_next.value_selector = SELECT_RESET;
      state_next.sa = SA_RESET;
      state_next.unlock = UNLOCK_RESET;
      state_next.locked_write = 1'b0;
      state_next.present = 1'b0;
      state_next.rdata = ZERO_WORD;
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg.header <= cap_header_s'(CAP_HEADER_RESET);
      state_reg.value_selector <= SELECT_RESET;
      state_reg.sa <= SA_RESET;
      state_reg.unlock <= UNLOCK_RESET;
      state_reg.locked_write <= 1'b0;
      state_reg.present <= 1'b0;
      state_reg.rdata <= ZERO_WORD;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign rdata = state_reg.rdata;
  assign system_allocated_flag = state_reg.sa;
  assign budget_value_unlock = state_reg.unlock;
  assign capability_present = state_reg.present;

endmodule

//--- pwr_budget_monitor.sv
// Port assertions for the power budget register bank.
// Assumes it is bound to the bank and fed by a same-clock master.
`timescale 1ns/1ps
module pwr_budget_monitor
  import pwr_budget_pkg::*;
(
  // Clock and resets
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hot_reset,
  // Register port and status
  input wire bus_req_s req,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic system_allocated_flag,
  input wire logic budget_value_unlock,
  input wire logic capability_present
);
  logic [SELECT_W-1:0] sel_reg;
  logic hdr_wr;
  logic flag_wr;
  assign hdr_wr = req.wr && req.addr == OFF_CAP_HEADER;
  assign flag_wr = req.wr && req.addr == OFF_CAP_FLAGS;
  // A shadow selector, since the window check needs the stored value.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= SELECT_RESET;
    end else if (hot_reset) begin
      sel_reg <= SELECT_RESET;
    end else if (req.wr && req.addr == OFF_DATA_SELECT) begin
      sel_reg <= req.wdata[SELECT_W-1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n || hot_reset);
  a_rdata_idle_zero: assert property (!req.rd |=> rdata == ZERO_WORD)
    else $error("read data not zero outside answer");
  a_window_high_zero: assert property (req.rd &&
    req.addr == OFF_DATA_WINDOW && sel_reg > SELECT_LAST |=> rdata == 0)
    else $error("window not zero for high selector");
  a_header_id_read: assert property (req.rd &&
    req.addr == OFF_CAP_HEADER && capability_present
    |=> rdata[19:0] == {CAP_VER_ONE, CAP_ID_POWER_BUDGET})
    else $error("header id or version wrong");
  a_flag_read: assert property (req.rd && req.addr == OFF_CAP_FLAGS
    |=> rdata == 32'($past(system_allocated_flag)))
    else $error("flags read wrong");
  a_locked_flag_kept: assert property (flag_wr && !budget_value_unlock
    |=> $stable(system_allocated_flag))
    else $error("locked flag write landed");
  a_unlock_write: assert property (req.wr &&
    req.addr == OFF_SWITCH_CONTROL
    |=> budget_value_unlock == $past(req.wdata[UNLOCK_BIT]))
    else $error("unlock bit not written");
  a_flag_write: assert property (flag_wr && budget_value_unlock
    |=> system_allocated_flag == $past(req.wdata[SA_BIT]))
    else $error("flag write lost");
  a_present_follows: assert property (hdr_wr && budget_value_unlock
    |=> capability_present == ($past(req.wdata[19:0]) == 20'h1_0004))
    else $error("present flag wrong");
  c_high_window: cover property (req.rd && sel_reg > SELECT_LAST);
  c_locked_write: cover property (flag_wr && !budget_value_unlock);
  c_present: cover property (hdr_wr ##1 capability_present);
endmodule
bind power_budget_capability_regs pwr_budget_monitor pwr_budget_monitor_inst (
  .clk(clk), .arst_n(arst_n), .hot_reset(hot_reset), .req(req),
  .rdata(rdata), .system_allocated_flag(system_allocated_flag),
  .budget_value_unlock(budget_value_unlock),
  .capability_present(capability_present));

//--- power_budget_capability_regs_bench.sv
// Self-checking bench for the power budget register bank.
// Assumes the bank and its package compile ahead of this file.
`timescale 1ns/1ps
module power_budget_capability_regs_bench import pwr_budget_pkg::*;;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hot_reset = 1'b0;
  bus_req_s req = '0;
  logic [DATA_W-1:0] rdata;
  logic sa_flag, unlock, present;
  logic [31:0] seed = 32'h40854447;
  logic [DATA_W-1:0] word [VALUE_COUNT];
  logic [DATA_W-1:0] got, hdr, r;
  logic [7:0] s;
  logic [7:0] hi_sel [4] = '{8'h08, 8'h1F, 8'hFF, 8'h80};
  int miscompares = 0;
  int checked = 0;
  always #4 clk = ~clk;
  power_budget_capability_regs power_budget_capability_regs_inst (
    .clk(clk), .arst_n(arst_n), .hot_reset(hot_reset), .req(req),
    .rdata(rdata), .system_allocated_flag(sa_flag),
    .budget_value_unlock(unlock), .capability_present(present));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] va(int i);
    return OFF_VALUE_BASE + 12'(VALUE_STRIDE * i);
  endfunction
  function automatic logic [31:0] win_exp(logic [7:0] sv);
    return (sv > SELECT_LAST) ? ZERO_WORD : word[sv[2:0]];
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic op(logic [11:0] a, logic [31:0] d, logic w, logic rd_s);
    @(posedge clk);
    req <= '{a, d, w, rd_s};
  endtask
  task automatic rd(logic [11:0] a);
    op(a, ZERO_WORD, 1'b0, 1'b1);
    @(posedge clk);
    req.rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic idle();
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic end_sim();
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFF_CAP_HEADER);
    check("header", got, CAP_HEADER_RESET);
    op(OFF_CAP_FLAGS, 32'h0000_0001, 1'b1, 1'b0);
    rd(OFF_CAP_FLAGS);
    check("locked flags", got, ZERO_WORD);
    op(OFF_SWITCH_CONTROL, 32'h0000_0001, 1'b1, 1'b0);
    idle();
    check("unlock", 32'(unlock), 32'h0000_0001);
    for (int i = 0; i < VALUE_COUNT; i++) begin
      word[i] = rnd();
      op(va(i), word[i], 1'b1, 1'b0);
    end
    for (int i = 0; i < VALUE_COUNT; i++) begin
      rd(va(i));
      check("value word", got, word[i]);
    end
    for (int i = 0; i < 12; i++) begin
      s = (i < 8) ? 8'(i) : hi_sel[i-8];
      r = rnd();
      op(OFF_DATA_SELECT, {r[31:8], s}, 1'b1, 1'b0);
      rd(OFF_DATA_WINDOW);
      check("window", got, win_exp(s));
      rd(OFF_DATA_SELECT);
      check("selector", got, {24'h00_0000, s});
    end
    hdr = rnd();
    hdr[19:0] = 20'h1_0004;
    op(OFF_CAP_HEADER, hdr, 1'b1, 1'b0);
    rd(OFF_CAP_HEADER);
    check("header", got, hdr);
    check("present", 32'(present), 32'h0000_0001);
    hdr[19:16] = 4'h2;
    op(OFF_CAP_HEADER, hdr, 1'b1, 1'b0);
    idle();
    check("present", 32'(present), ZERO_WORD);
    op(OFF_CAP_FLAGS, 32'hFFFF_FFFF, 1'b1, 1'b0);
    rd(OFF_CAP_FLAGS);
    check("flags", got, 32'h0000_0001);
    check("sa out", 32'(sa_flag), 32'h0000_0001);
    rd(12'h320);
    check("past last word", got, ZERO_WORD);
    rd(12'h302);
    check("misaligned", got, ZERO_WORD);
    op(OFF_SWITCH_CONTROL, ZERO_WORD, 1'b1, 1'b0);
    for (int i = 0; i < VALUE_COUNT; i++) begin
      op(va(i), rnd(), 1'b1, 1'b0);
    end
    for (int i = 0; i < VALUE_COUNT; i++) begin
      rd(va(i));
      check("locked word", got, word[i]);
    end
    op(OFF_CAP_HEADER, rnd(), 1'b1, 1'b0);
    rd(OFF_CAP_HEADER);
    check("locked header", got, hdr);
    rd(OFF_LOCK_STATUS);
    check("refused status", got, 32'h0000_0001);
    op(OFF_LOCK_STATUS, 32'h0000_0001, 1'b1, 1'b0);
    rd(OFF_LOCK_STATUS);
    check("status cleared", got, ZERO_WORD);
    @(posedge clk);
    hot_reset <= 1'b1;
    @(posedge clk);
    hot_reset <= 1'b0;
    rd(OFF_CAP_FLAGS);
    check("flags", got, ZERO_WORD);
    check("sa out", 32'(sa_flag), ZERO_WORD);
    check("unlock", 32'(unlock), ZERO_WORD);
    rd(OFF_CAP_HEADER);
    check("header", got, CAP_HEADER_RESET);
    for (int i = 0; i < VALUE_COUNT; i++) begin
      rd(va(i));
      check("sticky word", got, word[i]);
    end
    end_sim();
  end
endmodule
